// ---- verilog/ttm_defs.vh ----
// Constants for the triple timer module: register map, field positions, modes.
// Assumes a word-addressed 24-bit peripheral data bus, one access per cycle.
`ifndef TTM_DEFS_VH
`define TTM_DEFS_VH
`define TTM_W 24
`define TTM_PRE_W 21
`define TTM_ADDR_W 4
// Word addresses; timer n block at n*4, prescaler after the three timers
`define TTM_OFS_CSR 2'h0
`define TTM_OFS_CNT 2'h1
`define TTM_OFS_LOAD 2'h2
`define TTM_OFS_CMP 2'h3
`define TTM_ADDR_PLOAD 4'hC
`define TTM_ADDR_PCNT 4'hD
// Control-status fields
`define TTM_B_TE 0
`define TTM_B_OVERFLOW_IRQ_ENABLE 1
`define TTM_B_COMPARE_IRQ_ENABLE 2
`define TTM_B_INV 8
`define TTM_B_TRM 9
`define TTM_B_DIR 11
`define TTM_B_DI 12
`define TTM_B_DO 13
`define TTM_B_PCE 15
`define TTM_B_OFF 20
`define TTM_B_CMF 21
`define TTM_MODE_HI 7
`define TTM_MODE_LO 4
`define TTM_CSR_WMASK 24'h00_BBF7
`define TTM_CSR_RST 24'h00_0000
// Modes
`define TTM_M_GPIO 4'h0
`define TTM_M_PULSE 4'h1
`define TTM_M_TOGGLE 4'h2
`define TTM_M_EVENT 4'h3
`define TTM_M_WIDTH 4'h4
`define TTM_M_PERIOD 4'h5
`define TTM_M_CAPTURE 4'h6
`define TTM_M_PWM 4'h7
`define TTM_M_WD_PULSE 4'h9
`define TTM_M_WD_TOGGLE 4'hA
`endif

// ---- verilog/ttm_triple_timer.v ----
// Triple timer module: shared prescaler, three 24-bit timers, register port.
// Assumes timer_io pins are resolved outside from out/oe; svc strobes come from interrupt logic.
`include "ttm_defs.vh"
module ttm_triple_timer (
    input wire clk,
    input wire rstn,
    input wire sw_reset,
    input wire bus_wr,
    input wire bus_rd,
    input wire [`TTM_ADDR_W-1:0] bus_addr,
    input wire [`TTM_W-1:0] bus_wdata,
    output reg [`TTM_W-1:0] bus_rdata,
    input wire [2:0] ovf_svc,
    input wire [2:0] cmp_svc,
    input wire [2:0] timer_io_in,
    output reg [2:0] timer_io_out,
    output reg [2:0] timer_io_oe,
    output reg [2:0] ovf_irq,
    output reg [2:0] cmp_irq,
    output reg [2:0] dma_req
);
    function is_meas;
        input [3:0] m;
        begin
            is_meas = (m == `TTM_M_WIDTH) || (m == `TTM_M_PERIOD) || (m == `TTM_M_CAPTURE);
        end
    endfunction

    function is_outmode;
        input [3:0] m;
        begin
            is_outmode = (m == `TTM_M_PULSE) || (m == `TTM_M_TOGGLE) || (m == `TTM_M_PWM) ||
                (m == `TTM_M_WD_PULSE) || (m == `TTM_M_WD_TOGGLE);
        end
    endfunction

    wire clr = ~rstn | sw_reset;
    reg [`TTM_W-1:0] prescaler_load_reg;
    reg [`TTM_W-1:0] prescaler_count_reg;
    reg pre_tick;
    reg [2:0] pin_s1;
    reg [2:0] pin_s2;
    reg [2:0] pin_d;

    // Shared prescaler: counts down from the load value, one-cycle tick at zero
    always @(posedge clk)
    begin
        if (clr)
        begin
            prescaler_load_reg <= {`TTM_W{1'b0}};
            prescaler_count_reg <= {`TTM_W{1'b0}};
            pre_tick <= 1'b0;
        end
        else
        begin
            if (bus_wr && bus_addr == `TTM_ADDR_PLOAD)
                prescaler_load_reg <= {{(`TTM_W-`TTM_PRE_W){1'b0}}, bus_wdata[`TTM_PRE_W-1:0]};
            pre_tick <= (prescaler_count_reg == {`TTM_W{1'b0}});
            if (prescaler_count_reg == {`TTM_W{1'b0}})
                prescaler_count_reg <= prescaler_load_reg;
            else
                prescaler_count_reg <= prescaler_count_reg - 1'b1;
        end
    end

    // Two-stage synchroniser on the pins, then a delay stage for edges
    always @(posedge clk)
    begin
        if (~rstn)
        begin
            pin_s1 <= 3'h0;
            pin_s2 <= 3'h0;
            pin_d <= 3'h0;
        end
        else
        begin
            pin_s1 <= timer_io_in;
            pin_s2 <= pin_s1;
            pin_d <= pin_s2;
        end
    end

    wire [`TTM_W-1:0] csr_rd [0:2];
    wire [`TTM_W-1:0] cnt_rd [0:2];
    wire [`TTM_W-1:0] cmp_rd [0:2];

    genvar g;
    generate
        for (g = 0; g < 3; g = g + 1)
        begin : tmr
            reg [`TTM_W-1:0] ctrl_status_reg;
            reg [`TTM_W-1:0] count_value_reg;
            reg [`TTM_W-1:0] load_value_reg;
            reg [`TTM_W-1:0] compare_value_reg;
            reg first_clk;
            reg reload_pend;
            reg started;
            wire sel = bus_addr[`TTM_ADDR_W-1:2] == g;
            wire wr_csr = bus_wr && sel && bus_addr[1:0] == `TTM_OFS_CSR;
            wire [3:0] mode = ctrl_status_reg[`TTM_MODE_HI:`TTM_MODE_LO];
            wire te = ctrl_status_reg[`TTM_B_TE];
            wire inv = ctrl_status_reg[`TTM_B_INV];
            wire rise = pin_s2[g] & ~pin_d[g];
            wire fall = ~pin_s2[g] & pin_d[g];
            wire act_edge = inv ? fall : rise;
            wire ext_clk = (mode == `TTM_M_EVENT) && !ctrl_status_reg[`TTM_B_PCE];
            wire int_tick = ctrl_status_reg[`TTM_B_PCE] ? pre_tick : 1'b1;
            wire meas_gate = (mode == `TTM_M_WIDTH) ? (pin_s2[g] ^ inv) : 1'b1;
            wire tick = te && (ext_clk ? act_edge : int_tick) && (!is_meas(mode) || (started && meas_gate));
            wire at_max = count_value_reg == {`TTM_W{1'b1}};
            wire match = !is_meas(mode) && tick && !first_clk && !reload_pend &&
                (count_value_reg + 1'b1 == compare_value_reg);
            // Width ends on trailing edge, period/capture on the active edge
            wire meas_ev = te && is_meas(mode) && started && ((mode == `TTM_M_WIDTH) ? (inv ? rise : fall) : act_edge);
            wire cmp_ev = match | meas_ev;
            wire ovf_ev = tick && !first_clk && !reload_pend && at_max;
            wire csr_w1c_o = wr_csr && bus_wdata[`TTM_B_OFF];
            wire csr_w1c_c = wr_csr && bus_wdata[`TTM_B_CMF];
            wire te_rise = wr_csr && bus_wdata[`TTM_B_TE] && !te;

            assign csr_rd[g] = ctrl_status_reg;
            assign cnt_rd[g] = count_value_reg;
            assign cmp_rd[g] = compare_value_reg;

            always @(posedge clk)
            begin
                if (clr)
                begin
                    ctrl_status_reg <= `TTM_CSR_RST;
                    count_value_reg <= {`TTM_W{1'b0}};
                    load_value_reg <= {`TTM_W{1'b0}};
                    compare_value_reg <= {`TTM_W{1'b0}};
                    first_clk <= 1'b0;
                    reload_pend <= 1'b0;
                    started <= 1'b0;
                    timer_io_out[g] <= 1'b0;
                    timer_io_oe[g] <= 1'b0;
                    ovf_irq[g] <= 1'b0;
                    cmp_irq[g] <= 1'b0;
                    dma_req[g] <= 1'b0;
                end
                else
                begin
                    if (wr_csr)
                        ctrl_status_reg <= (bus_wdata & `TTM_CSR_WMASK) | (ctrl_status_reg & ~`TTM_CSR_WMASK);
                    // Set wins over write-one and service clears
                    if (ovf_ev)
                        ctrl_status_reg[`TTM_B_OFF] <= 1'b1;
                    else if (csr_w1c_o || ovf_svc[g])
                        ctrl_status_reg[`TTM_B_OFF] <= 1'b0;
                    if (cmp_ev)
                        ctrl_status_reg[`TTM_B_CMF] <= 1'b1;
                    else if (csr_w1c_c || cmp_svc[g])
                        ctrl_status_reg[`TTM_B_CMF] <= 1'b0;
                    // GPIO input bit tracks the pin when the pin is an input
                    if (!timer_io_oe[g])
                        ctrl_status_reg[`TTM_B_DI] <= pin_s2[g];
                    if (bus_wr && sel && bus_addr[1:0] == `TTM_OFS_LOAD)
                        load_value_reg <= bus_wdata;
                    if (bus_wr && sel && bus_addr[1:0] == `TTM_OFS_CMP)
                        compare_value_reg <= bus_wdata;
                    if (te_rise)
                    begin
                        count_value_reg <= {`TTM_W{1'b0}};
                        first_clk <= 1'b1;
                        reload_pend <= 1'b0;
                        started <= 1'b0;
                    end
                    else if (te)
                    begin
                        if (is_meas(mode) && act_edge && !started)
                            started <= 1'b1;
                        if (meas_ev && mode != `TTM_M_WIDTH)
                            count_value_reg <= load_value_reg;
                        else if (tick)
                        begin
                            if (first_clk || reload_pend)
                                count_value_reg <= load_value_reg;
                            else
                                count_value_reg <= count_value_reg + 1'b1;
                            first_clk <= 1'b0;
                            reload_pend <= match && ctrl_status_reg[`TTM_B_TRM];
                        end
                    end
                    // Pin: output modes drive while enabled, GPIO mode follows DIR/DO, all else listens
                    if (te && is_outmode(mode))
                    begin
                        timer_io_oe[g] <= 1'b1;
                        if (te_rise || first_clk)
                            timer_io_out[g] <= inv;
                        else if (match && (mode == `TTM_M_TOGGLE || mode == `TTM_M_WD_TOGGLE || mode == `TTM_M_PWM))
                            timer_io_out[g] <= ~timer_io_out[g];
                        else if (match)
                            timer_io_out[g] <= ~inv;
                        else if (tick && mode != `TTM_M_TOGGLE && mode != `TTM_M_WD_TOGGLE)
                            timer_io_out[g] <= inv;
                    end
                    else if (mode == `TTM_M_GPIO)
                    begin
                        timer_io_oe[g] <= ctrl_status_reg[`TTM_B_DIR];
                        timer_io_out[g] <= ctrl_status_reg[`TTM_B_DO];
                    end
                    else
                        timer_io_oe[g] <= 1'b0;
                    ovf_irq[g] <= ctrl_status_reg[`TTM_B_OFF] && ctrl_status_reg[`TTM_B_OVERFLOW_IRQ_ENABLE];
                    // Compare request held back while overflow request stands
                    cmp_irq[g] <= ctrl_status_reg[`TTM_B_CMF] && ctrl_status_reg[`TTM_B_COMPARE_IRQ_ENABLE] &&
                        !(ctrl_status_reg[`TTM_B_OFF] && ctrl_status_reg[`TTM_B_OVERFLOW_IRQ_ENABLE]);
                    dma_req[g] <= cmp_ev;
                end
            end
        end
    endgenerate

    // Read port; timer load registers are write-only and read as zero, prescaler load reads back
    always @(posedge clk)
    begin
        if (~rstn)
            bus_rdata <= {`TTM_W{1'b0}};
        else if (bus_rd)
        begin
            if (bus_addr == `TTM_ADDR_PLOAD)
                bus_rdata <= prescaler_load_reg;
            else if (bus_addr == `TTM_ADDR_PCNT)
                bus_rdata <= prescaler_count_reg;
            else if (bus_addr[`TTM_ADDR_W-1:2] < 2'h3)
            begin
                case (bus_addr[1:0])
                    `TTM_OFS_CSR: bus_rdata <= csr_rd[bus_addr[`TTM_ADDR_W-1:2]];
                    `TTM_OFS_CNT: bus_rdata <= cnt_rd[bus_addr[`TTM_ADDR_W-1:2]];
                    `TTM_OFS_CMP: bus_rdata <= cmp_rd[bus_addr[`TTM_ADDR_W-1:2]];
                    default: bus_rdata <= {`TTM_W{1'b0}};
                endcase
            end
            else
                bus_rdata <= {`TTM_W{1'b0}};
        end
    end
endmodule // ttm_triple_timer

// ---- testbench/ttm_pin_model.sv ----
// Model of the three timer pins and the equipment outside them.
// Assumes a pull-up per pin; outside source drives only while enabled.
module ttm_pin_model (
    input wire [2:0] ext_en,
    input wire [2:0] ext_val,
    input wire [2:0] io_out,
    input wire [2:0] io_oe,
    output wire [2:0] pin
);
    // Timer drive wins, then outside source, else pull-up
    assign pin = (io_oe & io_out) | (~io_oe & ext_en & ext_val) | (~io_oe & ~ext_en);
endmodule // ttm_pin_model

// ---- testbench/ttm_triple_timer_sva.sv ----
// Checker for the register port and request outputs of the triple timer.
// Assumes it is bound to ttm_triple_timer and sees its ports only.
module ttm_triple_timer_sva (
    input wire clk,
    input wire rstn,
    input wire sw_reset,
    input wire bus_wr,
    input wire bus_rd,
    input wire [3:0] bus_addr,
    input wire [23:0] bus_wdata,
    input wire [23:0] bus_rdata,
    input wire [2:0] ovf_svc,
    input wire [2:0] cmp_svc,
    input wire [2:0] timer_io_in,
    input wire [2:0] timer_io_out,
    input wire [2:0] timer_io_oe,
    input wire [2:0] ovf_irq,
    input wire [2:0] cmp_irq,
    input wire [2:0] dma_req
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rstn);
    property p_quiet;
        $rose(rstn) |-> (ovf_irq | cmp_irq | dma_req | timer_io_oe) == 3'h0;
    endproperty
    a_quiet: assert property (p_quiet) else $error("outputs active after reset");
    property p_load_zero;
        bus_rd && bus_addr[1:0] == 2'h2 |=> bus_rdata == 24'h00_0000;
    endproperty
    a_load_zero: assert property (p_load_zero) else $error("load word read not zero");
    property p_unmapped;
        bus_rd && bus_addr == 4'hF |=> bus_rdata == 24'h00_0000;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
    property p_prio;
        |ovf_irq |-> (ovf_irq & cmp_irq) == 3'h0;
    endproperty
    a_prio: assert property (p_prio) else $error("compare request beside overflow");
    property p_mode;
        bus_wr && bus_addr == 4'h4 && !sw_reset ##1 !bus_wr && !sw_reset ##1 bus_rd && !bus_wr && bus_addr == 4'h4
            |=> bus_rdata[7:0] == ($past(bus_wdata[7:0], 3) & 8'hF7);
    endproperty
    a_mode: assert property (p_mode) else $error("mode and enable readback wrong");
    property p_sw_clear;
        sw_reset ##1 bus_rd && bus_addr[1:0] == 2'h0 && bus_addr != 4'hC |=> (bus_rdata & 24'hFF_EFFF) == 24'h00_0000;
    endproperty
    a_sw_clear: assert property (p_sw_clear) else $error("control not cleared by soft reset");
    property p_sw_gpio;
        sw_reset |=> ##1 timer_io_oe == 3'h0;
    endproperty
    a_sw_gpio: assert property (p_sw_gpio) else $error("pin driven after soft reset");
    property p_hold;
        !bus_rd |=> $stable(bus_rdata);
    endproperty
    a_hold: assert property (p_hold) else $error("read data changed without read");
    c_ovf: cover property (ovf_irq[0]);
    c_cmp: cover property (cmp_irq[2]);
    c_dma: cover property (dma_req[0]);
endmodule // ttm_triple_timer_sva
bind ttm_triple_timer ttm_triple_timer_sva i_sva (.clk(clk), .rstn(rstn), .sw_reset(sw_reset), .bus_wr(bus_wr),
    .bus_rd(bus_rd), .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_rdata(bus_rdata), .ovf_svc(ovf_svc),
    .cmp_svc(cmp_svc), .timer_io_in(timer_io_in), .timer_io_out(timer_io_out), .timer_io_oe(timer_io_oe),
    .ovf_irq(ovf_irq), .cmp_irq(cmp_irq), .dma_req(dma_req));

// ---- testbench/ttm_triple_timer_tb_top.sv ----
// Self-checking bench for the triple timer: register tasks, scenario sequence.
// Assumes the pin model resolves the pins and the checker is bound.
module ttm_triple_timer_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
`define CHK(n, e, g) begin num_checks++; if ((g) !== (e)) begin mismatches++; $display("[FAIL] %s exp %h got %h", n, e, g); end end
    reg clk = 1'b0, rstn = 1'b0, sw_reset = 1'b0, bus_wr = 1'b0, bus_rd = 1'b0, saw_dma = 1'b0;
    reg [3:0] bus_addr = 4'h0;
    reg [23:0] bus_wdata = 24'h00_0000, d1, d2;
    reg [2:0] ovf_svc = 3'h0, cmp_svc = 3'h0, ext_en = 3'h0, ext_val = 3'h0;
    reg [3:0] modes [10] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7, 4'h9, 4'hA};
    wire [23:0] bus_rdata;
    wire [2:0] pin, io_out, io_oe, ovf_irq, cmp_irq, dma_req;
    int mismatches = 0;
    int num_checks = 0;
    always #4 clk = ~clk;
    always @(posedge clk) if (dma_req[0]) saw_dma <= 1'b1;
    ttm_triple_timer i_dut (.clk(clk), .rstn(rstn), .sw_reset(sw_reset), .bus_wr(bus_wr), .bus_rd(bus_rd),
        .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_rdata(bus_rdata), .ovf_svc(ovf_svc), .cmp_svc(cmp_svc),
        .timer_io_in(pin), .timer_io_out(io_out), .timer_io_oe(io_oe), .ovf_irq(ovf_irq), .cmp_irq(cmp_irq),
        .dma_req(dma_req));
    ttm_pin_model i_pins (.ext_en(ext_en), .ext_val(ext_val), .io_out(io_out), .io_oe(io_oe), .pin(pin));
    task automatic wr(input [3:0] a, input [23:0] d);
        bus_addr = a;
        bus_wdata = d;
        bus_wr = 1'b1;
        @(negedge clk);
        bus_wr = 1'b0;
        @(negedge clk);
    endtask
    task automatic rd(input [3:0] a, output [23:0] d);
        bus_addr = a;
        bus_rd = 1'b1;
        @(negedge clk);
        bus_rd = 1'b0;
        d = bus_rdata;
        @(negedge clk);
    endtask
    task automatic summarize;
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    initial
    begin
        repeat (16) @(negedge clk);
        rstn = 1'b1;
        for (int t = 0; t < 3; t++)
        begin
            rd(4'(t * 4), d1);
            `CHK("csr reset", 24'h00_0000, d1 & 24'hFF_EFFF)
        end
        rd(4'h2, d1);
        `CHK("load read", 24'h00_0000, d1)
        wr(4'h1, 24'h12_3456);
        rd(4'h1, d1);
        `CHK("count write", 24'h00_0000, d1)
        rd(4'hF, d1);
        `CHK("unmapped", 24'h00_0000, d1)
        foreach (modes[i])
        begin
            wr(4'h4, {16'h0000, modes[i], 4'h0});
            rd(4'h4, d1);
            `CHK("mode", {modes[i], 4'h0}, d1[7:0])
        end
        $display("test registers done");
        wr(4'h0, 24'h00_0000);
        wr(4'hC, 24'h00_0000);
        wr(4'h2, 24'hFF_FFF0);
        wr(4'h3, 24'h00_0003);
        wr(4'h0, 24'h00_0007);
        rd(4'h1, d1);
        rd(4'h1, d2);
        `CHK("count load", 20'hF_FFFF, d1[23:4])
        `CHK("count step", d1 + 24'h00_0002, d2)
        for (int i = 0; i < 40 && ovf_irq[0] !== 1'b1; i++) @(negedge clk);
        `CHK("ovf irq", 1'b1, ovf_irq[0])
        repeat (8) @(negedge clk);
        `CHK("cmp held", 1'b0, cmp_irq[0])
        rd(4'h0, d1);
        `CHK("flags", 2'b11, d1[21:20])
        `CHK("dma", 1'b1, saw_dma)
        ovf_svc = 3'b001;
        @(negedge clk);
        ovf_svc = 3'b000;
        repeat (3) @(negedge clk);
        `CHK("ovf clr", 2'b01, {ovf_irq[0], cmp_irq[0]})
        wr(4'h0, 24'h00_0000);
        rd(4'h1, d1);
        rd(4'h1, d2);
        `CHK("stopped", d1, d2)
        rd(4'h0, d1);
        `CHK("cmp kept", 2'b10, d1[21:20])
        wr(4'h0, 24'h20_0000);
        rd(4'h0, d1);
        `CHK("cmp clr", 2'b00, d1[21:20])
        $display("test timer0 done");
        wr(4'h4, 24'h00_2800);
        repeat (3) @(negedge clk);
        `CHK("gpio out", 2'b11, {io_oe[1], io_out[1]})
        wr(4'hA, 24'h00_0000);
        wr(4'hB, 24'h00_0003);
        ext_en[2] = 1'b1;
        wr(4'h8, 24'h00_0035);
        repeat (6)
        begin
            repeat (4) @(negedge clk);
            ext_val[2] = 1'b1;
            repeat (4) @(negedge clk);
            ext_val[2] = 1'b0;
        end
        rd(4'h8, d1);
        `CHK("event cmp", 2'b11, {d1[21], cmp_irq[2]})
        $display("test pins done");
        sw_reset = 1'b1;
        @(negedge clk);
        sw_reset = 1'b0;
        rd(4'h8, d1);
        `CHK("sw csr", 24'h00_0000, d1 & 24'hFF_EFFF)
        `CHK("sw pins", 3'h0, io_oe)
        $display("test soft reset done");
        summarize();
    end
    initial
    begin
        repeat (4000) @(posedge clk);
        mismatches++;
        summarize();
    end
endmodule // ttm_triple_timer_tb_top
